// [design/csz_regs.vh]
// register offsets, fields, reset values and timing constants of the calibration/zone block
`ifndef CSZ_REGS_VH
`define CSZ_REGS_VH
// register byte offsets
`define CSZ_CTRL_OFS      8'h00
`define CSZ_STATUS_OFS    8'h04
`define CSZ_HEAD_OFS      8'h08
`define CSZ_SPIN_TGT_OFS  8'h0C
`define CSZ_SPIN_MEAS_OFS 8'h10
`define CSZ_CAL_CNT_OFS   8'h14
`define CSZ_ZONE_TAB_OFS  8'h40
// field positions
`define CSZ_CTRL_CAL_EN   0
`define CSZ_ST_CAL_RUN    0
`define CSZ_ST_CMD_BUSY   1
`define CSZ_ST_WFAULT     2
`define CSZ_ST_SHIFT_BSY  3
`define CSZ_ST_ZONE_LSB   4
`define CSZ_ST_GC_ERR     8
// reset values
`define CSZ_CTRL_RST      32'h0000_0001
`define CSZ_SPIN_TGT_RST  24'h01_2C4B
// timing: one millisecond in ns, clock period in ns
`define CSZ_MS_NS         1000000
`define CSZ_CLK_NS        10
`define CSZ_CAL_PERIOD_MS 1800000
`define CSZ_CMD_WAIT_MS   100
// zone geometry
`define CSZ_ZONES         15
`define CSZ_LAST_CYL      14'h3DFE
`endif

// [design/csz_top.v]
// calibration scheduler, group coder, zone setup, head port, write fault and spindle timing
`include "csz_regs.vh"
module csz_top #(
  parameter MS_CYC     = `CSZ_MS_NS / `CSZ_CLK_NS,  // cycles per millisecond
  parameter PERIOD_MS  = `CSZ_CAL_PERIOD_MS,        // calibration spacing
  parameter CAL_LEN_MS = 50,                        // length of one pass
  parameter HEAD_DIV   = 4                          // head port clock half period
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // host command handshake
  input  wire        cmd_req_i,
  input  wire        cmd_done_i,
  output reg         cmd_grant_o,
  output reg         cal_run_o,
  // target cylinder and read channel setup
  input  wire [13:0] target_cyl_i,
  output reg  [7:0]  rate_word_o,
  output reg  [7:0]  filter_cut_o,
  output reg  [7:0]  boost_gain_o,
  output reg         setup_strobe_o,
  output reg         zone_ready_o,
  // write path
  input  wire [47:0] wr_data_i,
  input  wire        wr_valid_i,
  output reg  [50:0] wr_code_o,
  output reg         wr_code_valid_o,
  // read path
  input  wire [50:0] rd_code_i,
  input  wire        rd_code_valid_i,
  output reg  [47:0] rd_data_o,
  output reg         rd_data_valid_o,
  // head preamplifier port
  output reg         head_port_enable_o,
  output reg         head_port_clock_o,
  output reg         head_port_serial_data_o,
  input  wire        write_fault_sense_i,
  // spindle
  input  wire        spin_tick_i,
  output reg         spin_faster_o,
  output reg         spin_slower_o
);
  // scheduler states
  localparam S_IDLE = 2'd0;
  localparam S_CAL  = 2'd1;
  localparam S_CMD  = 2'd2;
  // zone lookup by cylinder, zone 0 at the outer edge
  function [3:0] zone_of;
    input [13:0] cyl;
    begin
      if (cyl <= 14'd1230) zone_of = 4'd0;
      else if (cyl <= 14'd2560) zone_of = 4'd1;
      else if (cyl <= 14'd3820) zone_of = 4'd2;
      else if (cyl <= 14'd5610) zone_of = 4'd3;
      else if (cyl <= 14'd6510) zone_of = 4'd4;
      else if (cyl <= 14'd6940) zone_of = 4'd5;
      else if (cyl <= 14'd8640) zone_of = 4'd6;
      else if (cyl <= 14'd9530) zone_of = 4'd7;
      else if (cyl <= 14'd10870) zone_of = 4'd8;
      else if (cyl <= 14'd11530) zone_of = 4'd9;
      else if (cyl <= 14'd12200) zone_of = 4'd10;
      else if (cyl <= 14'd13300) zone_of = 4'd11;
      else if (cyl <= 14'd14030) zone_of = 4'd12;
      else if (cyl <= 14'd15160) zone_of = 4'd13;
      else zone_of = 4'd14;
    end
  endfunction
  // pin synchronisers
  reg [1:0] req_sync_reg;    // host request
  reg [1:0] wf_sync_reg;     // write fault sense
  reg [2:0] tick_sync_reg;   // spindle tick, bit 2 is edge history
  wire      req_s  = req_sync_reg[1];
  wire      wf_s   = wf_sync_reg[1];
  wire      tick_p = tick_sync_reg[1] & ~tick_sync_reg[2];
  // two flops before any logic looks at the pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      req_sync_reg  <= 2'b00;
      wf_sync_reg   <= 2'b00;
      tick_sync_reg <= 3'b000;
    end else begin
      req_sync_reg  <= {req_sync_reg[0], cmd_req_i};
      wf_sync_reg   <= {wf_sync_reg[0], write_fault_sense_i};
      tick_sync_reg <= {tick_sync_reg[1:0], spin_tick_i};
    end
  end
  // software registers
  reg [31:0] ctrl_reg;               // bit0 enables the schedule
  reg [23:0] spin_tgt_reg;           // target cycles per sixth revolution
  reg [23:0] zone_tab_reg [0:14];    // per zone {boost, cut-off, rate}
  reg        wfault_reg;             // sticky write fault
  reg        gc_err_reg;             // sticky decode guard error
  reg [15:0] cal_cnt_reg;            // passes started
  reg [23:0] spin_meas_reg;          // last measured tick interval
  wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wb_wr  = wb_req & wb_we_i;
  wire [7:0] zidx   = (wb_adr_i - `CSZ_ZONE_TAB_OFS) >> 2;
  wire       in_tab = (wb_adr_i >= `CSZ_ZONE_TAB_OFS) && (zidx < 8'd15) && (wb_adr_i[1:0] == 2'b00);
  integer    i;
  // register writes honour byte lanes
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg     <= `CSZ_CTRL_RST;
      spin_tgt_reg <= `CSZ_SPIN_TGT_RST;
      for (i = 0; i < `CSZ_ZONES; i = i + 1)
        zone_tab_reg[i] <= 24'h00_0000;
    end else if (wb_wr) begin
      if (wb_adr_i == `CSZ_CTRL_OFS && wb_sel_i[0])
        ctrl_reg[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i == `CSZ_SPIN_TGT_OFS) begin
        if (wb_sel_i[0]) spin_tgt_reg[7:0]   <= wb_dat_i[7:0];
        if (wb_sel_i[1]) spin_tgt_reg[15:8]  <= wb_dat_i[15:8];
        if (wb_sel_i[2]) spin_tgt_reg[23:16] <= wb_dat_i[23:16];
      end
      if (in_tab) begin
        if (wb_sel_i[0]) zone_tab_reg[zidx[3:0]][7:0]   <= wb_dat_i[7:0];
        if (wb_sel_i[1]) zone_tab_reg[zidx[3:0]][15:8]  <= wb_dat_i[15:8];
        if (wb_sel_i[2]) zone_tab_reg[zidx[3:0]][23:16] <= wb_dat_i[23:16];
      end
    end
  end
  // calibration scheduler
  reg [1:0]  state_reg;
  reg [31:0] ms_pre_reg;     // millisecond prescaler
  reg [31:0] elapsed_reg;    // ms since last schedule point
  reg [31:0] cal_ms_reg;     // ms spent in current pass
  reg        cal_pend_reg;   // a pass is owed
  wire       ms_tick = (ms_pre_reg == MS_CYC - 1);
  // free running elapsed time, never held by commands
  always @(posedge clk_i) begin
    if (rst_i) begin
      ms_pre_reg  <= 32'h0000_0000;
      elapsed_reg <= 32'h0000_0000;
    end else begin
      ms_pre_reg <= ms_tick ? 32'h0000_0000 : ms_pre_reg + 32'h0000_0001;
      if (ms_tick)
        elapsed_reg <= (elapsed_reg == PERIOD_MS - 1) ? 32'h0000_0000 : elapsed_reg + 32'h0000_0001;
    end
  end
  // state machine: idle, calibrating, serving a command
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= S_IDLE;
      cal_pend_reg <= 1'b1;                      // initial pass owed
      cal_ms_reg   <= 32'h0000_0000;
      cal_run_o    <= 1'b0;
      cmd_grant_o  <= 1'b0;
      cal_cnt_reg  <= 16'h0000;
    end else begin
      cmd_grant_o <= 1'b0;
      // schedule point sets the owed flag
      if (ms_tick && elapsed_reg == PERIOD_MS - 1 && ctrl_reg[`CSZ_CTRL_CAL_EN])
        cal_pend_reg <= 1'b1;
      case (state_reg)
        S_IDLE: begin
          if (req_s) begin
            state_reg   <= S_CMD;
            cmd_grant_o <= 1'b1;
          end else if (cal_pend_reg) begin
            state_reg    <= S_CAL;
            cal_pend_reg <= 1'b0;
            cal_ms_reg   <= 32'h0000_0000;
            cal_run_o    <= 1'b1;
            cal_cnt_reg  <= cal_cnt_reg + 16'h0001;
          end
        end
        S_CAL: begin
          if (req_s) begin
            // abandon the pass and owe it again
            state_reg    <= S_CMD;
            cal_run_o    <= 1'b0;
            cmd_grant_o  <= 1'b1;                // three cycles after request pin, far under limit
            cal_pend_reg <= 1'b1;
          end else if (ms_tick) begin
            if (cal_ms_reg == CAL_LEN_MS - 1) begin
              state_reg <= S_IDLE;
              cal_run_o <= 1'b0;
            end else
              cal_ms_reg <= cal_ms_reg + 32'h0000_0001;
          end
        end
        S_CMD: begin
          // after seek and transfer, idle restarts any owed pass
          if (cmd_done_i)
            state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
          cal_run_o <= 1'b0;
        end
      endcase
    end
  end
  // zone tracking and read channel setup
  reg [3:0] zone_reg;
  reg       zone_vld_reg;
  wire [3:0] zone_now = zone_of(target_cyl_i);  // cylinder 0 outermost
  // on each zone change load rate, cut-off and boost
  always @(posedge clk_i) begin
    if (rst_i) begin
      zone_reg       <= 4'h0;
      zone_vld_reg   <= 1'b0;
      rate_word_o    <= 8'h00;
      filter_cut_o   <= 8'h00;
      boost_gain_o   <= 8'h00;
      setup_strobe_o <= 1'b0;
      zone_ready_o   <= 1'b0;
    end else begin
      setup_strobe_o <= 1'b0;
      if (!zone_vld_reg || zone_now != zone_reg) begin
        zone_reg       <= zone_now;
        zone_vld_reg   <= 1'b1;
        rate_word_o    <= zone_tab_reg[zone_now][7:0];
        filter_cut_o   <= zone_tab_reg[zone_now][15:8];
        boost_gain_o   <= zone_tab_reg[zone_now][23:16];
        setup_strobe_o <= 1'b1;
        zone_ready_o   <= 1'b0;              // transfer waits one cycle for setup
      end else
        zone_ready_o <= 1'b1;
    end
  end
  // group coder: a one guard bit after each 16-bit slice
  wire rd_guard_ok = rd_code_i[34] & rd_code_i[17] & rd_code_i[0];
  // encode on write strobe, decode on read strobe
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_code_o       <= 51'h0;
      wr_code_valid_o <= 1'b0;
      rd_data_o       <= 48'h0;
      rd_data_valid_o <= 1'b0;
      gc_err_reg      <= 1'b0;
      wfault_reg      <= 1'b0;
    end else begin
      wr_code_valid_o <= wr_valid_i;
      if (wr_valid_i)
        wr_code_o <= {wr_data_i[47:32], 1'b1, wr_data_i[31:16], 1'b1, wr_data_i[15:0], 1'b1};
      rd_data_valid_o <= rd_code_valid_i;
      if (rd_code_valid_i)
        rd_data_o <= {rd_code_i[50:35], rd_code_i[33:18], rd_code_i[16:1]};
      // set beats a clear in the same cycle
      if (rd_code_valid_i && !rd_guard_ok)
        gc_err_reg <= 1'b1;
      else if (wb_wr && wb_adr_i == `CSZ_STATUS_OFS && wb_sel_i[1] && wb_dat_i[`CSZ_ST_GC_ERR])
        gc_err_reg <= 1'b0;
      if (wf_s)                                  // sticky write fault, set wins over clear
        wfault_reg <= 1'b1;
      else if (wb_wr && wb_adr_i == `CSZ_STATUS_OFS && wb_sel_i[0] && wb_dat_i[`CSZ_ST_WFAULT])
        wfault_reg <= 1'b0;
    end
  end
  // head select shifter, msb first, data steady on rising clock
  reg [7:0] hs_sh_reg;
  reg [3:0] hs_bits_reg;
  reg [7:0] hs_div_reg;
  wire      hs_start = wb_wr && wb_adr_i == `CSZ_HEAD_OFS && wb_sel_i[0] && hs_bits_reg == 4'd0;
  // three-wire head port transfer
  always @(posedge clk_i) begin
    if (rst_i) begin
      hs_sh_reg               <= 8'h00;
      hs_bits_reg             <= 4'd0;
      hs_div_reg              <= 8'h00;
      head_port_enable_o      <= 1'b0;
      head_port_clock_o       <= 1'b0;
      head_port_serial_data_o <= 1'b0;
    end else if (hs_start) begin
      hs_sh_reg               <= {wb_dat_i[6:0], 1'b0};
      head_port_serial_data_o <= wb_dat_i[7];
      hs_bits_reg             <= 4'd8;
      hs_div_reg              <= 8'h00;
      head_port_enable_o      <= 1'b1;
    end else if (hs_bits_reg != 4'd0) begin
      if (hs_div_reg == HEAD_DIV - 1) begin
        hs_div_reg        <= 8'h00;
        head_port_clock_o <= ~head_port_clock_o;
        if (head_port_clock_o) begin
          // falling edge moves to next bit
          hs_bits_reg             <= hs_bits_reg - 4'd1;
          head_port_serial_data_o <= hs_sh_reg[7];
          hs_sh_reg               <= {hs_sh_reg[6:0], 1'b0};
          if (hs_bits_reg == 4'd1) begin
            head_port_enable_o      <= 1'b0;
            head_port_serial_data_o <= 1'b0;
          end
        end
      end else
        hs_div_reg <= hs_div_reg + 8'h01;
    end
  end
  // spindle: interval between ticks, correction on every tick whose interval differs from the target
  reg [23:0] spin_cnt_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      spin_cnt_reg  <= 24'h00_0000;
      spin_meas_reg <= 24'h00_0000;
      spin_faster_o <= 1'b0;
      spin_slower_o <= 1'b0;
    end else begin
      spin_faster_o <= 1'b0;
      spin_slower_o <= 1'b0;
      if (tick_p) begin
        spin_meas_reg <= spin_cnt_reg;
        spin_cnt_reg  <= 24'h00_0001;
        spin_faster_o <= spin_cnt_reg > spin_tgt_reg;   // too slow, more current
        spin_slower_o <= spin_cnt_reg < spin_tgt_reg;   // too fast, less current
      end else if (spin_cnt_reg != 24'hFF_FFFF)
        spin_cnt_reg <= spin_cnt_reg + 24'h00_0001;
    end
  end
  // bus answer one cycle after the request, unmapped reads give zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `CSZ_CTRL_OFS:      wb_dat_o <= {24'h00_0000, ctrl_reg[7:0]};
          `CSZ_STATUS_OFS:    wb_dat_o <= {23'h0, gc_err_reg, zone_reg, hs_bits_reg != 4'd0,
                                           wfault_reg, state_reg == S_CMD, cal_run_o};
          `CSZ_SPIN_TGT_OFS:  wb_dat_o <= {8'h00, spin_tgt_reg};
          `CSZ_SPIN_MEAS_OFS: wb_dat_o <= {8'h00, spin_meas_reg};
          `CSZ_CAL_CNT_OFS:   wb_dat_o <= {16'h0000, cal_cnt_reg};
          default:
            if (in_tab)
              wb_dat_o <= {8'h00, zone_tab_reg[zidx[3:0]]};
        endcase
      end
    end
  end
endmodule // csz_top

// [tb/csz_top_asserts.sv]
// port-level checker of the calibration, coder, zone, head port and spindle logic
module csz_top_asserts (
  // clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // bus and command handshake
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire        cmd_req_i,
  input wire        cmd_grant_o,
  input wire        cal_run_o,
  // zone setup, coder paths
  input wire        setup_strobe_o,
  input wire        zone_ready_o,
  input wire [47:0] wr_data_i,
  input wire        wr_valid_i,
  input wire [50:0] wr_code_o,
  input wire        wr_code_valid_o,
  input wire [50:0] rd_code_i,
  input wire        rd_code_valid_i,
  input wire [47:0] rd_data_o,
  input wire        rd_data_valid_o,
  // head port and spindle
  input wire        head_port_enable_o,
  input wire        head_port_clock_o,
  input wire        spin_faster_o,
  input wire        spin_slower_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // a pass starts right after reset release
  property p_init; $fell(rst_i) && !cmd_req_i |-> ##[1:3] cal_run_o; endproperty
  a_init: assert property (p_init) else $error("no pass after reset");
  // a request during a pass is granted quickly
  property p_pre; $rose(cmd_req_i) && cal_run_o |-> ##[1:5] cmd_grant_o; endproperty
  a_pre: assert property (p_pre) else $error("request not granted");
  // grant leaves no pass running and lasts one cycle
  property p_grant; cmd_grant_o |-> !cal_run_o ##1 !cmd_grant_o; endproperty
  a_grant: assert property (p_grant) else $error("grant with pass running");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus cycle not acked");
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
  // encoder inserts a one after each 16-bit slice
  property p_enc;
    wr_valid_i |=> wr_code_valid_o && wr_code_o == {$past(wr_data_i[47:32]), 1'b1,
      $past(wr_data_i[31:16]), 1'b1, $past(wr_data_i[15:0]), 1'b1};
  endproperty
  a_enc: assert property (p_enc) else $error("bad write code");
  property p_dec;
    rd_code_valid_i |=> rd_data_valid_o && rd_data_o == {$past(rd_code_i[50:35]),
      $past(rd_code_i[33:18]), $past(rd_code_i[16:1])};
  endproperty
  a_dec: assert property (p_dec) else $error("bad read data");
  property p_strobe; setup_strobe_o |-> !zone_ready_o; endproperty
  a_strobe: assert property (p_strobe) else $error("ready during setup");
  property p_hclk; !head_port_enable_o |-> !head_port_clock_o; endproperty
  a_hclk: assert property (p_hclk) else $error("head clock outside frame");
  property p_spin; spin_faster_o |-> !spin_slower_o; endproperty
  a_spin: assert property (p_spin) else $error("both speed pulses");
  c_grant: cover property (cmd_grant_o);
  c_head: cover property ($rose(head_port_enable_o));
  c_spin: cover property (spin_slower_o);
endmodule // csz_top_asserts

bind csz_top csz_top_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cmd_req_i,
  .cmd_grant_o, .cal_run_o, .setup_strobe_o, .zone_ready_o, .wr_data_i, .wr_valid_i, .wr_code_o,
  .wr_code_valid_o, .rd_code_i, .rd_code_valid_i, .rd_data_o, .rd_data_valid_o,
  .head_port_enable_o, .head_port_clock_o, .spin_faster_o, .spin_slower_o);

// [tb/csz_head_preamplifier_model.sv]
// head preamplifier stand-in: serial head select receiver and write fault source
module csz_head_preamplifier_model (
  // clock
  input  wire        clk_i,
  // serial head select port
  input  wire        head_port_enable_i,
  input  wire        head_port_clock_i,
  input  wire        head_port_serial_data_i,
  // fault request from the bench, sensed level out
  input  wire        fault_cmd_i,
  output logic       write_fault_sense_o,
  // last frame received
  output logic [7:0] rx_byte_o,
  output logic [3:0] rx_bits_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_q_reg; // head clock one cycle ago
  logic en_q_reg;  // enable one cycle ago
  initial begin
    rx_byte_o = 8'h00;
    rx_bits_o = 4'h0;
  end
  // frame starts on enable rise, one bit taken per head clock rise, msb first
  always @(posedge clk_i) begin
    clk_q_reg <= head_port_clock_i;
    en_q_reg <= head_port_enable_i;
    if (head_port_enable_i && !en_q_reg) begin
      rx_bits_o <= 4'h0;
    end else if (head_port_enable_i && head_port_clock_i && !clk_q_reg) begin
      rx_byte_o <= {rx_byte_o[6:0], head_port_serial_data_i};
      rx_bits_o <= rx_bits_o + 4'h1;
    end
  end
  // head short or open shows as a high sense level
  assign write_fault_sense_o = fault_cmd_i;
endmodule // csz_head_preamplifier_model

// [tb/csz_top_test.sv]
// self-checking bench of the calibration, coder, zone, head port and spindle logic
`include "csz_regs.vh"
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
`define WAITF(c, n) begin w = 0; while (!(c) && w < n) begin @(posedge clk_i); w++; end end
module csz_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PER = 200; // cycles between schedule points
  logic        clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, fault_cmd = 0;
  logic        cmd_req_i = 0, cmd_done_i = 0, wr_valid_i = 0, rd_code_valid_i = 0, spin_tick_i = 0;
  logic [7:0]  wb_adr_i = 0;
  logic [3:0]  wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, q;
  logic [13:0] target_cyl_i = 0;
  logic [47:0] wr_data_i = 0;
  logic [50:0] rd_code_i = 0, code;
  wire  [31:0] wb_dat_o;
  wire  [7:0]  rate_word_o, filter_cut_o, boost_gain_o, rx_byte;
  wire  [50:0] wr_code_o;
  wire  [47:0] rd_data_o;
  wire  [3:0]  rx_bits;
  wire         wb_ack_o, cmd_grant_o, cal_run_o, setup_strobe_o, zone_ready_o, wr_code_valid_o;
  wire         rd_data_valid_o, head_port_enable_o, head_port_clock_o, head_port_serial_data_o;
  wire         write_fault_sense_i, spin_faster_o, spin_slower_o;
  int          err_count = 0, cmp_count = 0, w, cyc = 0, nf = 0, ns = 0, f0, s0;
  int          hi [15] = '{1230, 2560, 3820, 5610, 6510, 6940, 8640, 9530, 10870, 11530, 12200,
                           13300, 14030, 15160, 15870}; // last cylinder of each zone
  csz_top #(.MS_CYC(10), .PERIOD_MS(20), .CAL_LEN_MS(3), .HEAD_DIV(4)) DUT (.clk_i, .rst_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .cmd_req_i, .cmd_done_i, .cmd_grant_o, .cal_run_o, .target_cyl_i, .rate_word_o, .filter_cut_o,
    .boost_gain_o, .setup_strobe_o, .zone_ready_o, .wr_data_i, .wr_valid_i, .wr_code_o,
    .wr_code_valid_o, .rd_code_i, .rd_code_valid_i, .rd_data_o, .rd_data_valid_o,
    .head_port_enable_o, .head_port_clock_o, .head_port_serial_data_o, .write_fault_sense_i,
    .spin_tick_i, .spin_faster_o, .spin_slower_o);
  csz_head_preamplifier_model u_pm (.clk_i, .head_port_enable_i(head_port_enable_o),
    .head_port_clock_i(head_port_clock_o), .head_port_serial_data_i(head_port_serial_data_o),
    .fault_cmd_i(fault_cmd), .write_fault_sense_o(write_fault_sense_i), .rx_byte_o(rx_byte),
    .rx_bits_o(rx_bits));
  always #5 clk_i = ~clk_i;
  // cycle count from reset release, speed pulse tallies, hang limit
  always @(posedge clk_i) begin
    cyc <= rst_i ? 0 : cyc + 1;
    nf <= nf + spin_faster_o;
    ns <= ns + spin_slower_o;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  // one classic bus cycle, held until ack is seen
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    `WAITF(wb_ack_o === 1'b1, 20)
    `CHK("ack", 1'b1, wb_ack_o)
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_we_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic cmd(input int len);
    cmd_req_i <= 1;
    `WAITF(cmd_grant_o === 1'b1, 10)
    `CHK("grant", 1'b1, cmd_grant_o)
    `CHK("pass off", 1'b0, cal_run_o)
    repeat (len) @(posedge clk_i);
    cmd_req_i <= 0;
    // let the dropped request clear the synchroniser first, else idle grants it again
    repeat (3) @(posedge clk_i);
    cmd_done_i <= 1;
    @(posedge clk_i);
    cmd_done_i <= 0;
  endtask
  task automatic t_cal;
    `WAITF(cal_run_o === 1'b1, 5)
    `CHK("initial pass", 1'b1, cal_run_o)
    cmd(20);
    `WAITF(cal_run_o === 1'b1, 6)
    `CHK("pass restart", 1'b1, cal_run_o)
    `WAITF(cyc == PER + 50, 400)
    cmd(80);
    `WAITF(cal_run_o === 1'b1, 300)
    `CHK("schedule point", 1'b1, cyc > 2 * PER - 2 && cyc < 2 * PER + 6)
    $display("test cal done");
  endtask
  task automatic t_regs;
    wb(0, `CSZ_CTRL_OFS, 0);
    `CHK("ctrl", `CSZ_CTRL_RST, q)
    wb(0, `CSZ_SPIN_TGT_OFS, 0);
    `CHK("spin target", `CSZ_SPIN_TGT_RST, q[23:0])
    wb(0, 8'h3C, 0);
    `CHK("unmapped", 32'h0000_0000, q)
    $display("test regs done");
  endtask
  task automatic t_coder;
    code = {16'h1234, 1'b1, 16'h5678, 1'b1, 16'h9ABC, 1'b1};
    wr_data_i <= 48'h1234_5678_9ABC;
    wr_valid_i <= 1;
    @(posedge clk_i);
    wr_valid_i <= 0;
    `WAITF(wr_code_valid_o === 1'b1, 3)
    `CHK("encode", code, wr_code_o)
    rd_code_i <= code;
    rd_code_valid_i <= 1;
    @(posedge clk_i);
    rd_code_i <= code & ~51'h1;
    `WAITF(rd_data_valid_o === 1'b1, 3)
    `CHK("decode", 48'h1234_5678_9ABC, rd_data_o)
    rd_code_valid_i <= 0;
    wb(0, `CSZ_STATUS_OFS, 0);
    `CHK("guard error", 1'b1, q[`CSZ_ST_GC_ERR])
    wb(1, `CSZ_STATUS_OFS, 32'h0000_0100);
    wb(0, `CSZ_STATUS_OFS, 0);
    `CHK("guard clear", 1'b0, q[`CSZ_ST_GC_ERR])
    $display("test coder done");
  endtask
  task automatic t_zone;
    for (int z = 0; z < 15; z++) wb(1, 8'(`CSZ_ZONE_TAB_OFS + 4 * z), 32'(32'h00C0_8010 + z * 32'h0001_0101));
    // park in the last zone so that zone 0 is loaded again from the new table
    target_cyl_i <= 14'(hi[14]);
    repeat (3) @(posedge clk_i);
    for (int z = 0; z < 15; z++) begin
      for (int k = 0; k < 2; k++) begin
        target_cyl_i <= k ? 14'(hi[z]) : (z ? 14'(hi[z - 1] + 1) : 14'h0000);
        `WAITF(setup_strobe_o === 1'b1, 3)
        if (k == 0) `CHK("strobe", 1'b1, setup_strobe_o)
        else `CHK("no strobe", 1'b0, setup_strobe_o)
        repeat (2) @(posedge clk_i);
        `CHK("ready", 1'b1, zone_ready_o)
        `CHK("rate", 8'(8'h10 + z), rate_word_o)
        `CHK("cut", 8'(8'h80 + z), filter_cut_o)
        `CHK("boost", 8'(8'hC0 + z), boost_gain_o)
        wb(0, `CSZ_STATUS_OFS, 0);
        `CHK("zone", 4'(z), q[7:4])
      end
    end
    $display("test zone done");
  endtask
  task automatic t_head;
    wb(1, `CSZ_HEAD_OFS, 32'h0000_00A5);
    `WAITF(head_port_enable_o === 1'b1, 4)
    `WAITF(head_port_enable_o === 1'b0, 200)
    @(posedge clk_i);
    `CHK("head bits", 4'h8, rx_bits)
    `CHK("head byte", 8'hA5, rx_byte)
    fault_cmd <= 1;
    repeat (5) @(posedge clk_i);
    fault_cmd <= 0;
    repeat (3) @(posedge clk_i);
    wb(0, `CSZ_STATUS_OFS, 0);
    `CHK("fault", 1'b1, q[`CSZ_ST_WFAULT])
    wb(1, `CSZ_STATUS_OFS, 32'h0000_0004);
    wb(0, `CSZ_STATUS_OFS, 0);
    `CHK("fault clear", 1'b0, q[`CSZ_ST_WFAULT])
    $display("test head done");
  endtask
  // ticks at a fixed spacing: first primes the interval, the next three are judged
  task automatic ticks(input int gap);
    for (int i = 0; i < 4; i++) begin
      if (i == 1) begin
        f0 = nf;
        s0 = ns;
      end
      spin_tick_i <= 1;
      repeat (3) @(posedge clk_i);
      spin_tick_i <= 0;
      repeat (gap - 3) @(posedge clk_i);
    end
  endtask
  task automatic t_spin;
    wb(1, `CSZ_SPIN_TGT_OFS, 32'h0000_0064);
    ticks(150);
    `CHK("faster", 3, nf - f0)
    `CHK("no slower", 0, ns - s0)
    ticks(50);
    `CHK("slower", 3, ns - s0)
    `CHK("no faster", 0, nf - f0)
    $display("test spin done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    t_cal();
    t_regs();
    t_coder();
    t_zone();
    t_head();
    t_spin();
    stop_test();
  end
endmodule // csz_top_test
